// >>> rtl/wdog_map.vh
// register map, fields, reset values and timing of the watchdog / interval timer
`ifndef WDOG_MAP_VH
`define WDOG_MAP_VH
// byte offsets on the register bus
`define WDOG_CONTROL_OFS   8'h00
`define WDOG_FEED_PORT_OFS 8'h04
`define WDOG_STATUS_OFS    8'h08
`define WDOG_MASK_OFS      8'h0c
`define WDOG_COUNT_OFS     8'h10
`define WDOG_LAST_IDX      3'd4
// wdog_control fields
`define CTL_SEL_LSB        0
`define CTL_SEL_MSB        2
`define CTL_ENABLED_BIT    4
`define CTL_WDOG_FEED_PORT_BIT      5
// reset values of wdog_control
`define CTL_RST_WDOG       8'h30
`define CTL_RST_OTHER_EN   8'h10
`define CTL_RST_OTHER_DIS  8'h00
// status / mask fields
`define EV_INTERVAL_BIT    0
`define EV_BAD_FEED_BIT    1
`define EV_FEED_OK_BIT     2
`define EV_W               3
// feed bytes
`define FEED_FIRST         8'h1e
`define FEED_SECOND        8'he1
// timing
`define CLK_PERIOD_NS      10
`define WDOG_TICK_NS       1000000
`define WDOG_BASE_MS       16
`define WDOG_RST_PULSE_NS  1000
// bus answers
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`endif

// >>> rtl/watchdog_interval_timer.v
// watchdog timer with interval-timer fallback, AXI4-Lite register slave
// Behaviour
// - counter runs from its own always-on time base, not the cpu clock
// - enabled watchdog cannot be stopped by software; expiry resets the cpu
// - when disabled by configuration, counter is an interval timer raising an interrupt
// - three-bit select gives eight periods, 16 ms up to 2048 ms
// - enabled watchdog accepts one control write after reset; later writes ignored
// - with the cpu clock stopped the counter still runs, expires and resets
// - other chip reset sources hold the counter inactive while they last
// - a feed is byte 1e then byte e1 written to the feed port
// - other accesses may fall between the two feed writes
// - wrong feed sequence does not feed, a wrong byte sets the bad-feed status bit; expiry stays at its scheduled time
// - expiry holds the chip reset about one microsecond, then execution restarts
// - expiry in power down restarts the oscillator; release waits for stability
// - control resets to 30h after watchdog reset, 10h after others when enabled
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "wdog_map.vh"

module watchdog_interval_timer #(
  parameter TICK_CYCLES = `WDOG_TICK_NS / `CLK_PERIOD_NS,
  parameter DIV_W       = 17,
  parameter CNT_W       = 12,
  parameter ADDR_W      = 8
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              wdog_enable_cfg_i,
  input  wire              other_reset_i,
  input  wire              power_down_i,
  input  wire              osc_stable_i,
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  output wire              chip_reset_o,
  output wire              osc_start_o,
  output wire              irq_o
);

  localparam integer     TICK_M1    = TICK_CYCLES - 1;
  localparam [DIV_W-1:0] TICK_LAST  = TICK_M1[DIV_W-1:0];
  localparam integer     RST_CYCLES = `WDOG_RST_PULSE_NS / `CLK_PERIOD_NS;
  localparam integer     RST_M1     = RST_CYCLES - 1;
  localparam [7:0]       RST_LAST   = RST_M1[7:0];
  localparam integer     BASE_INT   = `WDOG_BASE_MS;
  localparam [CNT_W-1:0] BASE_TICKS = BASE_INT[CNT_W-1:0];
  localparam [7:0]       CTL_OTHER  = `CTL_RST_OTHER_EN;
  localparam [7:0]       CTL_WDOG   = `CTL_RST_WDOG;

  localparam [2:0] IDX_CTRL  = 3'd0;
  localparam [2:0] IDX_FEED  = 3'd1;
  localparam [2:0] IDX_STAT  = 3'd2;
  localparam [2:0] IDX_MASK  = 3'd3;
  localparam [2:0] IDX_COUNT = 3'd4;
  localparam [2:0] IDX_NONE  = 3'd7;

  localparam [1:0] RS_IDLE    = 2'd0;
  localparam [1:0] RS_PULSE   = 2'd1;
  localparam [1:0] RS_OSCWAIT = 2'd2;

  // register index of a byte address, IDX_NONE when unmapped
  function [2:0] reg_index;
    input [ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'b00 || a[ADDR_W-1:2] > {{(ADDR_W-5){1'b0}}, `WDOG_LAST_IDX})
        reg_index = IDX_NONE;
      else
        reg_index = a[4:2];
    end
  endfunction

  // expiry count in millisecond ticks: 16 ms doubled per select step
  function [CNT_W-1:0] period_ticks;
    input [2:0] sel;
    begin
      period_ticks = BASE_TICKS << sel;
    end
  endfunction

  reg              en_r;
  reg [DIV_W-1:0]  div_r;
  reg [CNT_W-1:0]  cnt_r;
  reg [2:0]        sel_r;
  reg              wdog_feed_port_flag_r;
  reg              lock_r;
  reg              armed_r;
  reg [`EV_W-1:0]  status_r;
  reg [`EV_W-1:0]  mask_r;
  reg [1:0]        rs_state_r;
  reg [7:0]        rs_cnt_r;
  reg              pd_seen_r;
  reg              chip_reset_r;
  reg              osc_start_r;

  reg              aw_full_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg              w_full_r;
  reg [7:0]        w_data_r;
  reg              w_strb0_r;
  reg              bvalid_r;
  reg [1:0]        bresp_r;
  reg              rvalid_r;
  reg [1:0]        rresp_r;
  reg [31:0]       rdata_r;

  wire [2:0] wr_idx   = reg_index(aw_addr_r);
  wire [2:0] rd_idx   = reg_index(s_axi_araddr_i);
  wire       do_wr    = aw_full_r && w_full_r && !bvalid_r;
  wire       wr_byte  = do_wr && w_strb0_r;
  wire       rd_take  = s_axi_arvalid_i && !rvalid_r;
  wire       feed_wr  = wr_byte && wr_idx == IDX_FEED;
  wire       ctrl_wr  = wr_byte && wr_idx == IDX_CTRL;
  wire       feed_ok  = feed_wr && armed_r && w_data_r == `FEED_SECOND;
  wire       feed_bad = feed_wr && !feed_ok && w_data_r != `FEED_FIRST;
  wire       ctrl_ok  = ctrl_wr && !(en_r && lock_r);
  wire       hold_cnt = other_reset_i || chip_reset_r;
  wire       tick     = div_r == TICK_LAST;
  // >= so a select lowered below the running count still expires promptly
  wire       expire   = tick && !hold_cnt && cnt_r >= period_ticks(sel_r) - 1'b1;
  wire       wdog_exp = expire && en_r && rs_state_r == RS_IDLE;
  wire       int_exp  = expire && !en_r;

  wire [`EV_W-1:0] events;
  assign events[`EV_INTERVAL_BIT] = int_exp;
  assign events[`EV_BAD_FEED_BIT] = feed_bad;
  assign events[`EV_FEED_OK_BIT]  = feed_ok;

  wire [7:0] ctrl_view;
  assign ctrl_view = {2'b00, wdog_feed_port_flag_r, en_r, 1'b0, sel_r};

  // configuration bit is caught as the block leaves reset
  always @(posedge clk_i) begin
    if (rst_i)
      en_r <= wdog_enable_cfg_i;
  end

  // time base: cleared by a feed or a hold, otherwise running, independent of whether the cpu clock runs
  always @(posedge clk_i) begin
    if (rst_i || hold_cnt || feed_ok)
      div_r <= {DIV_W{1'b0}};
    else if (tick)
      div_r <= {DIV_W{1'b0}};
    else
      div_r <= div_r + 1'b1;
  end

  // no register bit can stop this count in watchdog mode
  always @(posedge clk_i) begin
    if (rst_i || hold_cnt)
      cnt_r <= {CNT_W{1'b0}};
    else if (feed_ok)
      cnt_r <= {CNT_W{1'b0}};
    else if (expire)
      cnt_r <= {CNT_W{1'b0}};
    else if (tick)
      cnt_r <= cnt_r + 1'b1;
  end

  // feed recogniser; unrelated accesses in between do not disarm it
  always @(posedge clk_i) begin
    if (rst_i || hold_cnt)
      armed_r <= 1'b0;
    else if (feed_wr)
      armed_r <= w_data_r == `FEED_FIRST;
  end

  // control register, write-once while the watchdog is enabled
  always @(posedge clk_i) begin
    if (rst_i || other_reset_i) begin
      sel_r        <= CTL_OTHER[`CTL_SEL_MSB:`CTL_SEL_LSB];
      wdog_feed_port_flag_r <= CTL_OTHER[`CTL_WDOG_FEED_PORT_BIT];
      lock_r       <= 1'b0;
    end else if (wdog_exp) begin
      sel_r        <= CTL_WDOG[`CTL_SEL_MSB:`CTL_SEL_LSB];
      wdog_feed_port_flag_r <= CTL_WDOG[`CTL_WDOG_FEED_PORT_BIT];
      lock_r       <= 1'b0;
    end else if (ctrl_ok) begin
      sel_r        <= w_data_r[`CTL_SEL_MSB:`CTL_SEL_LSB];
      wdog_feed_port_flag_r <= wdog_feed_port_flag_r & w_data_r[`CTL_WDOG_FEED_PORT_BIT];
      lock_r       <= 1'b1;
    end
  end

  // chip reset sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      rs_state_r   <= RS_IDLE;
      rs_cnt_r     <= 8'h00;
      pd_seen_r    <= 1'b0;
      chip_reset_r <= 1'b0;
      osc_start_r  <= 1'b0;
    end else begin
      case (rs_state_r)
        RS_IDLE: begin
          if (wdog_exp) begin
            rs_state_r   <= RS_PULSE;
            rs_cnt_r     <= 8'h00;
            chip_reset_r <= 1'b1;
            pd_seen_r    <= power_down_i;
            osc_start_r  <= power_down_i;
          end
        end
        RS_PULSE: begin
          if (rs_cnt_r == RST_LAST) begin
            if (pd_seen_r) begin
              rs_state_r <= RS_OSCWAIT;
            end else begin
              rs_state_r   <= RS_IDLE;
              chip_reset_r <= 1'b0;
            end
          end else begin
            rs_cnt_r <= rs_cnt_r + 1'b1;
          end
        end
        RS_OSCWAIT: begin
          // release only once the restarted oscillator is usable
          if (osc_stable_i) begin
            rs_state_r   <= RS_IDLE;
            chip_reset_r <= 1'b0;
            osc_start_r  <= 1'b0;
            pd_seen_r    <= 1'b0;
          end
        end
        default: begin
          rs_state_r   <= RS_IDLE;
          chip_reset_r <= 1'b0;
          osc_start_r  <= 1'b0;
        end
      endcase
    end
  end

  // sticky events, cleared by reading status; a new event wins over the clear
  always @(posedge clk_i) begin
    if (rst_i)
      status_r <= {`EV_W{1'b0}};
    else if (rd_take && rd_idx == IDX_STAT)
      status_r <= events;
    else
      status_r <= status_r | events;
  end

  always @(posedge clk_i) begin
    if (rst_i)
      mask_r <= {`EV_W{1'b0}};
    else if (wr_byte && wr_idx == IDX_MASK)
      mask_r <= w_data_r[`EV_W-1:0];
  end

  // write channel: address and data taken in either order
  always @(posedge clk_i) begin
    if (rst_i) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_full_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_strb0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_r  <= 1'b1;
        w_data_r  <= s_axi_wdata_i[7:0];
        w_strb0_r <= s_axi_wstrb_i[0];
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (wr_idx == IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_r && s_axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel: one read outstanding, data registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rresp_r  <= (rd_idx == IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      case (rd_idx)
        IDX_CTRL:  rdata_r <= {24'h000000, ctrl_view};
        IDX_STAT:  rdata_r <= {{(32-`EV_W){1'b0}}, status_r};
        IDX_MASK:  rdata_r <= {{(32-`EV_W){1'b0}}, mask_r};
        IDX_COUNT: rdata_r <= {{(32-CNT_W){1'b0}}, cnt_r};
        default:   rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready_o = !aw_full_r && !bvalid_r;
  assign s_axi_wready_o  = !w_full_r && !bvalid_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = rdata_r;
  assign chip_reset_o    = chip_reset_r;
  assign osc_start_o     = osc_start_r;
  assign irq_o           = |(status_r & mask_r);

endmodule // watchdog_interval_timer

// >>> tb/watchdog_interval_timer_sva.sv
// port assertions for the watchdog / interval timer
`timescale 1ns/1ps
module watchdog_interval_timer_sva (
  input wire        clk_i,
  input wire        rst_i,
  input wire        other_reset_i,
  input wire        osc_stable_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_wready_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire        s_axi_rready_i,
  input wire        s_axi_rvalid_o,
  input wire [31:0] s_axi_rdata_o,
  input wire        chip_reset_o,
  input wire        osc_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pulse_len: assert property ($rose(chip_reset_o) && !osc_start_o |-> ##99 chip_reset_o ##1 !chip_reset_o)
    else $error("chip reset pulse length wrong");
  a_pulse_min: assert property ($rose(chip_reset_o) |-> chip_reset_o [*8])
    else $error("chip reset pulse too short");
  a_osc_hold: assert property (osc_start_o && !osc_stable_i |=> chip_reset_o)
    else $error("reset released before oscillator stable");
  a_osc_release: assert property ($fell(chip_reset_o) && $past(osc_start_o) |-> $past(osc_stable_i))
    else $error("reset fell without stable oscillator");
  a_other_hold: assert property (other_reset_i |=> !$rose(chip_reset_o))
    else $error("expiry during other reset");
  a_w_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write ready while response pending");
  a_r_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read ready while data pending");
  a_r_stand: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before taken");
  a_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
endmodule // watchdog_interval_timer_sva

bind watchdog_interval_timer watchdog_interval_timer_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .other_reset_i(other_reset_i), .osc_stable_i(osc_stable_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rdata_o(s_axi_rdata_o), .chip_reset_o(chip_reset_o),
  .osc_start_o(osc_start_o)
);

// >>> tb/tb_watchdog_interval_timer.sv
// self-checking bench for the watchdog / interval timer
`timescale 1ns/1ps
`include "wdog_map.vh"
module tb_watchdog_interval_timer;
  reg        clk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg        en_cfg = 1'b1;
  reg        oth_rst = 1'b0;
  reg        pdn = 1'b0;
  reg        osc_ok = 1'b0;
  reg [7:0]  awaddr = 8'h00;
  reg [7:0]  araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg        awvalid = 1'b0;
  reg        wvalid = 1'b0;
  reg        bready = 1'b0;
  reg        arvalid = 1'b0;
  reg        rready = 1'b0;
  wire       awready, wready, bvalid, arready, rvalid, chip_rst, osc_start, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer    bad_count = 0;
  integer    cmp_count = 0;
  integer    cyc = 0;
  integer    t0, i;
  reg [31:0] d;
  reg [1:0]  r;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  // short tick keeps the shortest period (select 0) at 160 cycles
  watchdog_interval_timer #(.TICK_CYCLES(10)) u_watchdog_interval_timer (
    .clk_i(clk_i), .rst_i(rst_i), .wdog_enable_cfg_i(en_cfg), .other_reset_i(oth_rst),
    .power_down_i(pdn), .osc_stable_i(osc_ok), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .chip_reset_o(chip_rst),
    .osc_start_o(osc_start), .irq_o(irq)
  );

  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task hang(input integer k);
    begin
      if (k >= 400) begin
        bad_count = bad_count + 1;
        print_verdict;
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] v);
    integer k;
    reg pa, pw;
    begin
      @(posedge clk_i);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      k = 0;
      while ((pa || pw || !bvalid) && k < 400) begin
        @(posedge clk_i);
        k = k + 1;
        if (pa && awready) begin
          pa = 1'b0;
          awvalid <= 1'b0;
        end
        if (pw && wready) begin
          pw = 1'b0;
          wvalid <= 1'b0;
        end
      end
      hang(k);
      chk("bresp", bresp, `RESP_OKAY);
      bready <= 1'b0;
    end
  endtask

  // rready comes one cycle late so the data is seen standing
  task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
    integer k;
    begin
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      k = 0;
      do begin
        @(posedge clk_i);
        k = k + 1;
      end while (!arready && k < 400);
      arvalid <= 1'b0;
      @(posedge clk_i);
      rready <= 1'b1;
      do begin
        @(posedge clk_i);
        k = k + 1;
      end while (!rvalid && k < 400);
      hang(k);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
    end
  endtask

  task wait_cr(input v, input integer lim);
    integer k;
    begin
      k = 0;
      while (chip_rst !== v && k < lim) begin
        @(posedge clk_i);
        k = k + 1;
      end
      hang(k >= lim ? 400 : 0);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`WDOG_CONTROL_OFS, d, r);
    chk("ctrl", d, 32'h10);
    rd(8'h14, d, r);
    chk("rresp", r, `RESP_SLVERR);
    wr(`WDOG_MASK_OFS, 32'h7);
    wr(`WDOG_FEED_PORT_OFS, 32'h1e);
    rd(`WDOG_COUNT_OFS, d, r);
    wr(`WDOG_FEED_PORT_OFS, 32'he1);
    chk("irq", irq, 1'b1);
    rd(`WDOG_STATUS_OFS, d, r);
    chk("status", d, 32'h4);
    rd(`WDOG_STATUS_OFS, d, r);
    chk("status", d, 32'h0);
    wr(`WDOG_FEED_PORT_OFS, 32'he1);
    rd(`WDOG_STATUS_OFS, d, r);
    chk("status", d, 32'h2);
    wr(`WDOG_CONTROL_OFS, 32'h1);
    wr(`WDOG_CONTROL_OFS, 32'h2);
    rd(`WDOG_CONTROL_OFS, d, r);
    chk("ctrl", d, 32'h11);
    oth_rst <= 1'b1;
    // any chip reset pulse during the hold would be caught here
    d = 32'h0;
    repeat (300) begin
      @(posedge clk_i);
      d = d | chip_rst;
    end
    chk("chip_rst", d, 32'h0);
    rd(`WDOG_COUNT_OFS, d, r);
    chk("count", d, 32'h0);
    oth_rst <= 1'b0;
    t0 = cyc;
    wr(`WDOG_FEED_PORT_OFS, 32'h1e);
    wr(`WDOG_FEED_PORT_OFS, 32'h55);
    wr(`WDOG_FEED_PORT_OFS, 32'he1);
    wait_cr(1'b1, 400);
    // 16 ticks of 10 clocks after the hold, seen one edge later
    chk("expiry", cyc - t0, 161);
    t0 = cyc;
    wait_cr(1'b0, 200);
    chk("pulse", cyc - t0, 100);
    rd(`WDOG_CONTROL_OFS, d, r);
    chk("ctrl", d, 32'h30);
    t0 = cyc;
    repeat (100) @(posedge clk_i);
    wr(`WDOG_FEED_PORT_OFS, 32'h1e);
    wr(`WDOG_FEED_PORT_OFS, 32'he1);
    wait_cr(1'b1, 400);
    chk("refeed", cyc - t0 >= 250 && cyc - t0 <= 290, 1);
    wait_cr(1'b0, 200);
    pdn <= 1'b1;
    wait_cr(1'b1, 400);
    chk("osc_start", osc_start, 1'b1);
    repeat (200) @(posedge clk_i);
    chk("chip_rst", chip_rst, 1'b1);
    osc_ok <= 1'b1;
    wait_cr(1'b0, 5);
    pdn <= 1'b0;
    en_cfg <= 1'b0;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`WDOG_CONTROL_OFS, d, r);
    chk("ctrl", d, 32'h0);
    for (i = 7; i >= 0; i = i - 1) begin
      wr(`WDOG_CONTROL_OFS, i);
      rd(`WDOG_CONTROL_OFS, d, r);
      chk("select", d, i);
    end
    wr(`WDOG_MASK_OFS, 32'h0);
    repeat (200) @(posedge clk_i);
    chk("irq", irq, 1'b0);
    chk("chip_rst", chip_rst, 1'b0);
    wr(`WDOG_MASK_OFS, 32'h1);
    chk("irq", irq, 1'b1);
    rd(`WDOG_STATUS_OFS, d, r);
    chk("status", d, 32'h1);
    @(posedge clk_i);
    chk("irq", irq, 1'b0);
    print_verdict;
  end
endmodule // tb_watchdog_interval_timer
